/* pkg/ecdhk_cfg.svh */
`ifndef ECDHK_CFG_SVH
`define ECDHK_CFG_SVH
// opcodes
`define ECDHK_OP_ECDH      8'h43
`define ECDHK_OP_KEY_GENERATE_COMMAND    8'h40
// ecdh modes, private key from a slot
`define ECDHK_M_SLOT_CLEAR 8'h0c
`define ECDHK_M_SLOT_ENC   8'h0e
`define ECDHK_M_SLOT_TK    8'h08
// ecdh modes, private key from the temporary key register
`define ECDHK_M_TK_CLEAR   8'h0d
`define ECDHK_M_TK_ENC     8'h0f
`define ECDHK_M_TK_TK      8'h09
`define ECDHK_M_TK_SLOT    8'h05
// key generate mode, private key into a slot
`define ECDHK_M_GEN_SLOT   8'h04
// status codes
`define ECDHK_ST_OK        8'h00
`define ECDHK_ST_PARSE     8'h03
`define ECDHK_ST_EXEC      8'h0f
`define ECDHK_ST_FAULT     8'h05
// public key length, last byte index of x then y
`define ECDHK_PK_LAST      6'h3f
// slot policy masks, one bit per slot
`define ECDHK_ECDH_SLOTS   16'h001d
`define ECDHK_GEN_SLOTS    16'h001c
`define ECDHK_ECC_SLOTS    16'h003f
`define ECDHK_STORE_SLOTS  16'hffff
// shared secret protect bit of the chip option word
`define ECDHK_PROTECT      1'b0
// register offsets and fields
`define ECDHK_A_CTRL       8'h00
`define ECDHK_A_STAT       8'h04
`define ECDHK_CTRL_TKSET   0
`define ECDHK_CTRL_TKCLR   1
`endif

/* pkg/ecdhk_pkg.sv */
`default_nettype none
package ecdhk_pkg;
  // handler states, one-hot
  typedef enum logic [4:0] {
    S_IDLE  = 5'h01,
    S_LOAD  = 5'h02,
    S_CHECK = 5'h04,
    S_RUN   = 5'h08,
    S_RESP  = 5'h10
  } ecdhk_state_t;
  // response shape
  typedef enum logic [1:0] {
    K_STATUS    = 2'h0,
    K_SECRET    = 2'h1,
    K_SEC_NONCE = 2'h2,
    K_PUBKEY    = 2'h3
  } ecdhk_kind_t;
  // where the result goes
  typedef enum logic [1:0] {
    D_OUTBUF  = 2'h0,
    D_TEMPORARY_KEY_REGISTER = 2'h1,
    D_SLOT    = 2'h2,
    D_NONE    = 2'h3
  } ecdhk_dest_t;
endpackage : ecdhk_pkg
`default_nettype wire

/* core/ecdhk_policy.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ecdhk_cfg.svh"
// ************************************************************
// command decode and slot policy, purely combinational
// ************************************************************
module ecdhk_policy import ecdhk_pkg::*; #(
  parameter logic [15:0] ECDH_SLOTS  = `ECDHK_ECDH_SLOTS,
  parameter logic [15:0] GEN_SLOTS   = `ECDHK_GEN_SLOTS,
  parameter logic [15:0] ECC_SLOTS   = `ECDHK_ECC_SLOTS,
  parameter logic [15:0] STORE_SLOTS = `ECDHK_STORE_SLOTS,
  parameter logic        PROTECT     = `ECDHK_PROTECT
) (
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  mode,
  input  wire logic [15:0] keysel,
  input  wire logic [15:0] slot_locked,
  output logic             accept,
  output logic [7:0]       err,
  output ecdhk_kind_t      kind,
  output ecdhk_dest_t      dest,
  output logic             tk_src,
  output logic             encrypt,
  output logic             key_generate_command
);
  // slot membership in a policy mask, upper selector bits must be zero
  function automatic logic slot_in(input logic [15:0] mask, input logic [15:0] sel);
    slot_in = (sel[15:4] == 12'h000) && mask[sel[3:0]];
  endfunction : slot_in

  // decode of opcode and mode
  always_comb begin
    accept  = 1'b0;
    err     = `ECDHK_ST_PARSE;
    kind    = K_STATUS;
    dest    = D_NONE;
    tk_src  = 1'b0;
    encrypt = 1'b0;
    key_generate_command  = 1'b0;
    if (opcode == `ECDHK_OP_ECDH) begin
      err = `ECDHK_ST_EXEC;
      case (mode)
        `ECDHK_M_SLOT_CLEAR: begin // clear unless protect bit
          accept  = slot_in(ECDH_SLOTS, keysel);
          dest    = D_OUTBUF;
          encrypt = PROTECT;
          kind    = PROTECT ? K_SEC_NONCE : K_SECRET;
        end
        `ECDHK_M_SLOT_ENC: begin // encrypted with nonce
          accept  = slot_in(ECDH_SLOTS, keysel);
          dest    = D_OUTBUF;
          encrypt = 1'b1;
          kind    = K_SEC_NONCE;
        end
        `ECDHK_M_SLOT_TK: begin // kept internally
          accept = slot_in(ECDH_SLOTS, keysel);
          dest   = D_TEMPORARY_KEY_REGISTER;
        end
        `ECDHK_M_TK_CLEAR: begin // selector must be zero
          accept  = (keysel == 16'h0000);
          tk_src  = 1'b1;
          dest    = D_OUTBUF;
          encrypt = PROTECT;
          kind    = PROTECT ? K_SEC_NONCE : K_SECRET;
        end
        `ECDHK_M_TK_ENC: begin
          accept  = (keysel == 16'h0000);
          tk_src  = 1'b1;
          dest    = D_OUTBUF;
          encrypt = 1'b1;
          kind    = K_SEC_NONCE;
        end
        `ECDHK_M_TK_TK: begin // result back to temporary key
          accept = (keysel == 16'h0000);
          tk_src = 1'b1;
          dest   = D_TEMPORARY_KEY_REGISTER;
        end
        `ECDHK_M_TK_SLOT: begin // result into named slot
          accept = slot_in(STORE_SLOTS, keysel) && !slot_locked[keysel[3:0]];
          tk_src = 1'b1;
          dest   = D_SLOT;
        end
        default: begin // unknown mode rejected
          accept = 1'b0;
          err    = `ECDHK_ST_PARSE;
        end
      endcase
    end else if (opcode == `ECDHK_OP_KEY_GENERATE_COMMAND && mode == `ECDHK_M_GEN_SLOT) begin
      err    = `ECDHK_ST_EXEC;
      key_generate_command = 1'b1;
      dest   = D_SLOT;
      kind   = K_PUBKEY;
      // ecc slots only, generate-capable, unlocked, no authorization
      accept = slot_in(ECC_SLOTS, keysel) && slot_in(GEN_SLOTS, keysel) && !slot_locked[keysel[3:0]];
    end
  end
endmodule : ecdhk_policy
`default_nettype wire

/* core/ecdhk_handler.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ecdhk_cfg.svh"
// Summary of operation
// - ecdh frame: opcode, mode, selector, x, y
// - slot mode 0c outputs clear secret
// - slot mode 0e outputs encrypted secret, nonce
// - slot mode 08 stores secret, status byte
// - failing output modes return one error byte
// - internal modes return 00 or error
// - protect bit set encrypts clear modes
// - protect bit zero by default, mode decides
// - temp mode 0d, selector zero, clear
// - temp mode 0f encrypted secret plus nonce
// - temp 09 keeps result, 05 writes slot
// - consume clears valid flag, writeback sets it
// - key generate only on ecc slots
// - key generate also derives public key
// - locked slot or invalid key errors
// - key generate slots 2-4, no authorization
// - slot ecdh only slots 0, 2-4
// - encryption uses io key, output only
// - key generate 40, mode 04, pubkey out
module ecdhk_handler import ecdhk_pkg::*; #(
  parameter logic [15:0] ECDH_SLOTS  = `ECDHK_ECDH_SLOTS,
  parameter logic [15:0] GEN_SLOTS   = `ECDHK_GEN_SLOTS,
  parameter logic [15:0] ECC_SLOTS   = `ECDHK_ECC_SLOTS,
  parameter logic [15:0] STORE_SLOTS = `ECDHK_STORE_SLOTS,
  parameter logic        PROTECT     = `ECDHK_PROTECT
) (
  input  wire logic        CLK_SYS,
  input  wire logic        ARST_N,
  // register port
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic [31:0]      RDATA,
  // command port
  input  wire logic        CMD_VALID,
  input  wire logic [7:0]  CMD_OPCODE,
  input  wire logic [7:0]  CMD_MODE,
  input  wire logic [15:0] CMD_KEYSEL,
  output logic             CMD_READY,
  input  wire logic        PK_VALID,
  input  wire logic [7:0]  PK_BYTE,
  input  wire logic [15:0] SLOT_LOCKED,
  // ecc engine
  output logic             ENG_START,
  output logic             ENG_KEY_GENERATE_COMMAND,
  output logic             ENG_DERIVE_PUB,
  output logic             ENG_TK_SRC,
  output logic [3:0]       ENG_SLOT,
  output ecdhk_dest_t      ENG_DEST,
  output logic             ENG_ENCRYPT,
  output logic [511:0]     ENG_PUBKEY,
  input  wire logic        ENG_DONE,
  input  wire logic        ENG_FAULT,
  // response
  output logic             RSP_VALID,
  output ecdhk_kind_t      RSP_KIND,
  output logic [7:0]       RSP_STATUS,
  output logic             RSP_ENCRYPT,
  output logic             TEMP_KEY_VALID
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    ecdhk_state_t state;   // handler state
    logic [7:0]   opcode;  // latched opcode
    logic [7:0]   mode;    // latched mode
    logic [15:0]  keysel;  // latched key selector
    logic [511:0] pk;      // peer public key, x then y
    logic [5:0]   cnt;     // public key byte count
    logic         ready;   // command accept
    logic         start;   // engine start pulse
    logic         key_generate_command;  // engine op is key generate
    logic         tk_src;  // private key from temporary key
    ecdhk_dest_t  dest;    // result destination
    logic         enc;     // io key encryption
    ecdhk_kind_t  kind;    // response shape on success
    logic         rvalid;  // response pulse
    ecdhk_kind_t  rkind;   // response shape
    logic [7:0]   rstat;   // status byte
    logic         renc;    // response encrypted
    logic         tk_valid; // temp key valid flag
    logic [31:0]  rdata;   // read data
  } ecdhk_regs_t;

  ecdhk_regs_t r;      // registered state
  ecdhk_regs_t next_r; // next state

  // policy outputs
  logic        p_accept;
  logic [7:0]  p_err;
  ecdhk_kind_t p_kind;
  ecdhk_dest_t p_dest;
  logic        p_tk_src;
  logic        p_enc;
  logic        p_key_generate_command;

  // ************************************************************
  // decode of the latched command
  // ************************************************************
  ecdhk_policy #(
    .ECDH_SLOTS  (ECDH_SLOTS),
    .GEN_SLOTS   (GEN_SLOTS),
    .ECC_SLOTS   (ECC_SLOTS),
    .STORE_SLOTS (STORE_SLOTS),
    .PROTECT     (PROTECT)
  ) u_policy (
    .opcode      (r.opcode),
    .mode        (r.mode),
    .keysel      (r.keysel),
    .slot_locked (SLOT_LOCKED),
    .accept      (p_accept),
    .err         (p_err),
    .kind        (p_kind),
    .dest        (p_dest),
    .tk_src      (p_tk_src),
    .encrypt     (p_enc),
    .key_generate_command      (p_key_generate_command)
  );

  // software write to control
  logic ctrl_wr;
  assign ctrl_wr = WR && (ADDR == `ECDHK_A_CTRL);

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_r        = r;
    next_r.start  = 1'b0;
    next_r.rvalid = 1'b0;
    next_r.rdata  = 32'h0000_0000;
    // software clear first, so a hardware writeback in the same cycle wins
    if (ctrl_wr && WDATA[`ECDHK_CTRL_TKCLR]) begin
      next_r.tk_valid = 1'b0;
    end
    case (r.state)
      S_IDLE: begin // wait for a command
        if (CMD_VALID) begin
          next_r.opcode = CMD_OPCODE;
          next_r.mode   = CMD_MODE;
          next_r.keysel = CMD_KEYSEL;
          next_r.cnt    = 6'h00;
          // only ecdh carries the 64-byte peer key
          next_r.state  = (CMD_OPCODE == `ECDHK_OP_ECDH) ? S_LOAD : S_CHECK;
        end
      end
      S_LOAD: begin // collect x then y, byte 0 first
        if (PK_VALID) begin
          next_r.pk[{r.cnt, 3'h0} +: 8] = PK_BYTE;
          next_r.cnt = r.cnt + 6'h01;
          if (r.cnt == `ECDHK_PK_LAST) begin
            next_r.state = S_CHECK;
          end
        end
      end
      S_CHECK: begin // policy decides run or reject
        if (p_accept) begin
          next_r.start  = 1'b1;
          next_r.key_generate_command = p_key_generate_command;
          next_r.tk_src = p_tk_src;
          next_r.dest   = p_dest;
          next_r.enc    = p_enc;
          next_r.kind   = p_kind;
          next_r.state  = S_RUN;
          if (p_tk_src) begin
            next_r.tk_valid = 1'b0; // consumed
          end
        end else begin
          next_r.rvalid = 1'b1; // single error byte
          next_r.rkind  = K_STATUS;
          next_r.rstat  = p_err;
          next_r.renc   = 1'b0;
          next_r.state  = S_RESP;
        end
      end
      S_RUN: begin // wait for the engine
        if (ENG_DONE) begin
          next_r.rvalid = 1'b1;
          next_r.state  = S_RESP;
          if (ENG_FAULT) begin
            next_r.rkind = K_STATUS; // fault or invalid key
            next_r.rstat = `ECDHK_ST_FAULT;
            next_r.renc  = 1'b0;
          end else begin
            next_r.rkind = r.kind;
            next_r.rstat = `ECDHK_ST_OK;
            next_r.renc  = r.enc;
            if (r.dest == D_TEMPORARY_KEY_REGISTER) begin
              next_r.tk_valid = 1'b1; // written back
            end
          end
        end
      end
      S_RESP: begin // response pulse stands one cycle
        next_r.state = S_IDLE;
      end
      default: begin // illegal code recovers to idle
        next_r.state = S_IDLE;
      end
    endcase
    // software set last, wins over its own clear and over consume
    if (ctrl_wr && WDATA[`ECDHK_CTRL_TKSET]) begin
      next_r.tk_valid = 1'b1;
    end
    // register reads, answer in the next cycle
    if (RD && ADDR == `ECDHK_A_STAT) begin
      next_r.rdata = {11'h000, r.state, r.rstat, 6'h00, (r.state != S_IDLE), r.tk_valid};
    end
    next_r.ready = (next_r.state == S_IDLE);
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      r        <= '0;
      r.state  <= S_IDLE;
      r.dest   <= D_NONE;
      r.ready  <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from the state register
  assign RDATA          = r.rdata;
  assign CMD_READY      = r.ready;
  assign ENG_START      = r.start;
  assign ENG_KEY_GENERATE_COMMAND     = r.key_generate_command;
  assign ENG_DERIVE_PUB = r.key_generate_command; // public key derived with the new key
  assign ENG_TK_SRC     = r.tk_src;
  assign ENG_SLOT       = r.keysel[3:0];
  assign ENG_DEST       = r.dest;
  assign ENG_ENCRYPT    = r.enc; // io protection key
  assign ENG_PUBKEY     = r.pk;
  assign RSP_VALID      = r.rvalid;
  assign RSP_KIND       = r.rkind;
  assign RSP_STATUS     = r.rstat;
  assign RSP_ENCRYPT    = r.renc;
  assign TEMP_KEY_VALID = r.tk_valid;

  // ************************************************************
  // checks
  // ************************************************************
  a_load_len_64: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (r.state == S_LOAD && PK_VALID && r.cnt == `ECDHK_PK_LAST) |=> (r.state == S_CHECK))
    else $error("public key load did not end after 64 bytes");

  a_slot_clear_out: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (RSP_VALID && RSP_STATUS == `ECDHK_ST_OK && r.opcode == `ECDHK_OP_ECDH
     && (r.mode == `ECDHK_M_SLOT_CLEAR || r.mode == `ECDHK_M_TK_CLEAR))
    |-> (RSP_KIND == K_SECRET && !RSP_ENCRYPT))
    else $error("clear mode response not a clear secret");

  a_enc_with_nonce: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (RSP_VALID && RSP_STATUS == `ECDHK_ST_OK && r.opcode == `ECDHK_OP_ECDH
     && (r.mode == `ECDHK_M_SLOT_ENC || r.mode == `ECDHK_M_TK_ENC))
    |-> (RSP_KIND == K_SEC_NONCE && RSP_ENCRYPT))
    else $error("encrypted mode response lacks encryption or nonce");

  a_tk_store_flag: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (r.state == S_RUN && ENG_DONE && !ENG_FAULT && r.dest == D_TEMPORARY_KEY_REGISTER)
    |=> (RSP_VALID && RSP_KIND == K_STATUS && TEMP_KEY_VALID))
    else $error("temporary key store did not set the valid flag");

  a_err_one_byte: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (RSP_VALID && RSP_STATUS != `ECDHK_ST_OK) |-> (RSP_KIND == K_STATUS && !RSP_ENCRYPT))
    else $error("error response is not a single status byte");

  a_tk_consume_clr: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (ENG_START && ENG_TK_SRC && !$past(ctrl_wr)) |-> !TEMP_KEY_VALID)
    else $error("temporary key valid flag not cleared on consume");

  a_key_generate_command_slots: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (ENG_START && ENG_KEY_GENERATE_COMMAND)
    |-> (ENG_DERIVE_PUB && ENG_SLOT inside {4'h2, 4'h3, 4'h4} && !SLOT_LOCKED[ENG_SLOT]))
    else $error("key generate started on a forbidden slot");

  a_ecdh_slots: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (ENG_START && !ENG_KEY_GENERATE_COMMAND && !ENG_TK_SRC) |-> (ENG_SLOT inside {4'h0, 4'h2, 4'h3, 4'h4}))
    else $error("slot ecdh started on a forbidden slot");

  a_fault_status: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (r.state == S_RUN && ENG_DONE && ENG_FAULT)
    |=> (RSP_VALID && RSP_STATUS == `ECDHK_ST_FAULT) ##1 (!RSP_VALID && CMD_READY))
    else $error("engine fault not reported as error");

  a_tk_sel_zero: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (ENG_START && ENG_TK_SRC && ENG_DEST != D_SLOT) |-> (r.keysel == 16'h0000))
    else $error("temporary key source started with nonzero selector");

  a_enc_outbuf: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (ENG_START && ENG_ENCRYPT) |-> (ENG_DEST == D_OUTBUF))
    else $error("encryption requested for internal destination");

  a_bad_mode_err: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (r.state == S_CHECK && !p_accept) |=> (RSP_VALID && RSP_STATUS != `ECDHK_ST_OK && !ENG_START))
    else $error("rejected command not answered with an error");
endmodule : ecdhk_handler
`default_nettype wire

/* tb/ecdhk_eng_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// ecc engine stand-in: done pulse after a prompt or slow wait
// ************************************************************
module ecdhk_eng_model (
  input  wire logic clk_sys,   // system clock
  input  wire logic arst_n,    // async reset, low
  input  wire logic start,     // engine start pulse
  input  wire logic slow,      // long wait when high
  input  wire logic fault_req, // report a failure at done
  output logic      done,      // done pulse
  output logic      fault      // failure level beside done
);
  logic [3:0] cnt;  // cycles left before done
  logic       busy; // operation in flight
  logic       tog;  // junk pattern outside done
  // countdown, then one done pulse
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
      cnt  <= 4'h0;
      done <= 1'b0;
      tog  <= 1'b0;
    end else begin
      done <= 1'b0;
      tog  <= ~tog;
      if (start) begin
        busy <= 1'b1;
        cnt  <= slow ? 4'h9 : 4'h0;
      end else if (busy) begin
        if (cnt == 4'h0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt <= cnt - 4'h1;
        end
      end
    end
  end
  // fault only meaningful with done, toggles otherwise
  assign fault = done ? fault_req : tog;
endmodule : ecdhk_eng_model
`default_nettype wire

/* tb/ecdhk_handler_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ecdhk_cfg.svh"
module ecdhk_handler_tb import ecdhk_pkg::*;;
  // ************************************************************
  // stimulus and observed signals
  // ************************************************************
  logic clk_sys = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00, cmd_opcode = 8'h00, cmd_mode = 8'h00, pk_byte = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic cmd_valid = 1'b0, pk_valid = 1'b0, f_req = 1'b0, slow = 1'b0;
  logic [15:0] cmd_keysel = 16'h0, slot_locked = 16'h0;
  logic cmd_ready, eng_start, eng_key_generate_command, eng_derive_pub, eng_tk_src, eng_encrypt;
  logic eng_done, eng_fault, rsp_valid, rsp_encrypt, temp_key_valid;
  logic [3:0] eng_slot;
  logic [511:0] eng_pubkey;
  logic [7:0] rsp_status;
  ecdhk_dest_t eng_dest, s_dest;
  ecdhk_kind_t rsp_kind;
  logic s_tk, s_gen, s_dp, s_enc; // engine request captured at start
  logic [3:0] s_slot;
  logic [7:0] s_pk0, s_pk63;
  int nstart = 0, fail_count = 0, checks = 0;
  // clock, 25 ns period
  always #12.5 clk_sys = ~clk_sys;
  ecdhk_handler dut (.CLK_SYS(clk_sys), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .CMD_VALID(cmd_valid), .CMD_OPCODE(cmd_opcode), .CMD_MODE(cmd_mode),
    .CMD_KEYSEL(cmd_keysel), .CMD_READY(cmd_ready), .PK_VALID(pk_valid), .PK_BYTE(pk_byte),
    .SLOT_LOCKED(slot_locked), .ENG_START(eng_start), .ENG_KEY_GENERATE_COMMAND(eng_key_generate_command),
    .ENG_DERIVE_PUB(eng_derive_pub), .ENG_TK_SRC(eng_tk_src), .ENG_SLOT(eng_slot), .ENG_DEST(eng_dest),
    .ENG_ENCRYPT(eng_encrypt), .ENG_PUBKEY(eng_pubkey), .ENG_DONE(eng_done), .ENG_FAULT(eng_fault),
    .RSP_VALID(rsp_valid), .RSP_KIND(rsp_kind), .RSP_STATUS(rsp_status), .RSP_ENCRYPT(rsp_encrypt),
    .TEMP_KEY_VALID(temp_key_valid));
  ecdhk_eng_model eng (.clk_sys(clk_sys), .arst_n(arst_n), .start(eng_start), .slow(slow),
    .fault_req(f_req), .done(eng_done), .fault(eng_fault));
  // capture the engine request when it starts
  always @(posedge clk_sys) begin
    if (eng_start === 1'b1) begin
      nstart <= nstart + 1;
      s_tk   <= eng_tk_src;
      s_dest <= eng_dest;
      s_gen  <= eng_key_generate_command;
      s_dp   <= eng_derive_pub;
      s_enc  <= eng_encrypt;
      s_slot <= eng_slot;
      s_pk0  <= eng_pubkey[7:0];
      s_pk63 <= eng_pubkey[511:504];
    end
  end
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test;
    if (fail_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  // register write, one strobe cycle
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : wr32
  // register read, data one cycle after the strobe
  task automatic rd32(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    addr <= a; rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd32
  // one command, key bytes for ecdh, then the response
  task automatic cmd(input logic [7:0] op, md, input logic [15:0] ks, input logic f,
                     input ecdhk_kind_t k, input logic [7:0] st);
    int n;
    int n0;
    n0 = nstart;
    n = 0;
    @(posedge clk_sys);
    cmd_valid <= 1'b1; cmd_opcode <= op; cmd_mode <= md; cmd_keysel <= ks; f_req <= f; slow <= ~slow;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    if (op == `ECDHK_OP_ECDH) begin
      for (int i = 0; i < 64; i++) begin // x bytes then y bytes
        pk_valid <= 1'b1; pk_byte <= 8'(i) ^ 8'h5a;
        @(posedge clk_sys);
      end
      pk_valid <= 1'b0;
    end
    do begin
      @(posedge clk_sys);
      #1 n++;
    end while (rsp_valid !== 1'b1 && n < 200);
    chk(32'(n < 200), 32'h1);
    chk({30'h0, rsp_kind}, {30'h0, k});
    chk({24'h0, rsp_status}, {24'h0, st});
    if (k != K_STATUS) chk({31'h0, rsp_encrypt}, {31'h0, k == K_SEC_NONCE});
    chk(nstart - n0, (st == `ECDHK_ST_EXEC || st == `ECDHK_ST_PARSE) ? 0 : 1);
    @(posedge clk_sys);
    #1 chk({31'h0, cmd_ready}, 32'h1);
  endtask : cmd
  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    #1 chk({31'h0, cmd_ready}, 32'h1);
    chk({31'h0, temp_key_valid}, 32'h0);
    rd32(`ECDHK_A_STAT, 32'h0001_0000);
    cmd(`ECDHK_OP_ECDH, `ECDHK_M_SLOT_CLEAR, 16'h0000, 0, K_SECRET, `ECDHK_ST_OK);
    chk({24'h0, s_pk0}, 32'h5a);
    chk({24'h0, s_pk63}, 32'h65);
    chk({30'h0, s_dest}, {30'h0, D_OUTBUF});
    chk({31'h0, s_enc}, 32'h0);
    cmd(`ECDHK_OP_ECDH, `ECDHK_M_SLOT_ENC, 16'h0002, 0, K_SEC_NONCE, `ECDHK_ST_OK);
    chk({31'h0, s_enc}, 32'h1);
    cmd(`ECDHK_OP_ECDH, `ECDHK_M_SLOT_TK, 16'h0003, 0, K_STATUS, `ECDHK_ST_OK);
    chk({30'h0, s_dest}, {30'h0, D_TEMPORARY_KEY_REGISTER});
    chk({31'h0, temp_key_valid}, 32'h1);
    cmd(`ECDHK_OP_ECDH, `ECDHK_M_TK_CLEAR, 16'h0000, 0, K_SECRET, `ECDHK_ST_OK);
    chk({31'h0, s_tk}, 32'h1);
    chk({31'h0, temp_key_valid}, 32'h0);
    wr32(`ECDHK_A_CTRL, 32'h1);
    rd32(`ECDHK_A_STAT, 32'h0001_0001);
    cmd(`ECDHK_OP_ECDH, `ECDHK_M_TK_ENC, 16'h0000, 0, K_SEC_NONCE, `ECDHK_ST_OK);
    chk({31'h0, temp_key_valid}, 32'h0);
    cmd(`ECDHK_OP_ECDH, `ECDHK_M_TK_TK, 16'h0000, 0, K_STATUS, `ECDHK_ST_OK);
    chk({31'h0, temp_key_valid}, 32'h1);
    cmd(`ECDHK_OP_ECDH, `ECDHK_M_TK_SLOT, 16'h0005, 0, K_STATUS, `ECDHK_ST_OK);
    chk({26'h0, s_dest, s_slot}, {26'h0, D_SLOT, 4'h5});
    chk({31'h0, temp_key_valid}, 32'h0);
    cmd(`ECDHK_OP_ECDH, `ECDHK_M_SLOT_CLEAR, 16'h0001, 0, K_STATUS, `ECDHK_ST_EXEC);
    cmd(`ECDHK_OP_ECDH, 8'h07, 16'h0000, 0, K_STATUS, `ECDHK_ST_PARSE);
    cmd(`ECDHK_OP_ECDH, `ECDHK_M_SLOT_ENC, 16'h0002, 1, K_STATUS, `ECDHK_ST_FAULT);
    cmd(`ECDHK_OP_ECDH, `ECDHK_M_TK_CLEAR, 16'h0001, 0, K_STATUS, `ECDHK_ST_EXEC);
    cmd(`ECDHK_OP_KEY_GENERATE_COMMAND, `ECDHK_M_GEN_SLOT, 16'h0002, 0, K_PUBKEY, `ECDHK_ST_OK);
    chk({30'h0, s_gen, s_dp}, 32'h3);
    cmd(`ECDHK_OP_KEY_GENERATE_COMMAND, `ECDHK_M_GEN_SLOT, 16'h0001, 0, K_STATUS, `ECDHK_ST_EXEC);
    cmd(`ECDHK_OP_KEY_GENERATE_COMMAND, `ECDHK_M_GEN_SLOT, 16'h0006, 0, K_STATUS, `ECDHK_ST_EXEC);
    @(posedge clk_sys) slot_locked <= 16'h0010;
    cmd(`ECDHK_OP_KEY_GENERATE_COMMAND, `ECDHK_M_GEN_SLOT, 16'h0004, 0, K_STATUS, `ECDHK_ST_EXEC);
    cmd(`ECDHK_OP_KEY_GENERATE_COMMAND, `ECDHK_M_GEN_SLOT, 16'h0003, 1, K_STATUS, `ECDHK_ST_FAULT);
    cmd(`ECDHK_OP_KEY_GENERATE_COMMAND, 8'h0c, 16'h0002, 0, K_STATUS, `ECDHK_ST_PARSE);
    wr32(`ECDHK_A_CTRL, 32'h2);
    rd32(`ECDHK_A_STAT, 32'h0001_0300);
    wr32(`ECDHK_A_CTRL, 32'h3);
    rd32(`ECDHK_A_STAT, 32'h0001_0301);
    rd32(`ECDHK_A_CTRL, 32'h0);
    rd32(8'h10, 32'h0);
    stop_test();
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    stop_test();
  end
endmodule : ecdhk_handler_tb
`default_nettype wire
